// >>> rdt_pkg.sv
package rdt_pkg;

    // ------------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------------
    localparam int RDT_AW = 4;
    localparam int RDT_DW = 16;
    localparam logic [RDT_AW-1:0] RDT_OFS_CSR = 4'h0;
    localparam logic [RDT_AW-1:0] RDT_OFS_CNT = 4'h4;
    localparam logic [RDT_AW-1:0] RDT_OFS_RLD = 4'h8;

    localparam int RDT_B_TRG = 0;
    localparam int RDT_B_COUNT_RUN_ENABLE = 1;
    localparam int RDT_B_UF = 2;
    localparam int RDT_B_UNDERFLOW_IRQ_ENABLE = 3;
    localparam int RDT_B_RELOAD_ENABLE = 4;
    localparam int RDT_B_OUTPUT_LEVEL_SELECT = 5;
    localparam int RDT_B_MOD_LO = 7;
    localparam int RDT_B_MOD_HI = 9;
    localparam int RDT_B_CSL_LO = 10;
    localparam int RDT_B_CSL_HI = 11;

    // ------------------------------------------------------------------
    // Reset values, encodings and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] RDT_CNT_RST = 16'h0000;
    localparam logic [15:0] RDT_CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] RDT_RLD_RST = 16'h0000;
    localparam logic [1:0] RDT_CSL_DIV2 = 2'h0;
    localparam logic [1:0] RDT_CSL_DIV8 = 2'h1;
    localparam logic [1:0] RDT_CSL_DIV32 = 2'h2;
    localparam logic [1:0] RDT_CSL_EXT = 2'h3;
    localparam logic [4:0] RDT_MASK_DIV2 = 5'h01;
    localparam logic [4:0] RDT_MASK_DIV8 = 5'h07;
    localparam logic [4:0] RDT_MASK_DIV32 = 5'h1f;
    localparam logic [1:0] RDT_EDGE_NONE = 2'h0;
    localparam logic [1:0] RDT_EDGE_RISE = 2'h1;
    localparam logic [1:0] RDT_EDGE_FALL = 2'h2;
    localparam logic [1:0] RDT_EDGE_BOTH = 2'h3;
    // Trigger to load delay, in peripheral clock periods.
    localparam int RDT_LOAD_DELAY_T = 1;

    typedef enum logic [1:0] {
        RDT_ST_STOP = 2'b00,
        RDT_ST_WAIT = 2'b01,
        RDT_ST_RUN = 2'b10
    } rdt_state_t;

    typedef struct packed {
        rdt_state_t state;
        logic [1:0] csl;
        logic [2:0] mode;
        logic output_level_select;
        logic reload_enable;
        logic underflow_irq_enable;
        logic uf;
        logic [15:0] count;
        logic [15:0] reload;
        logic [4:0] presc;
        logic load_pend;
        logic tog;
        logic [15:0] rdata;
        logic irq;
        logic dma_req;
        logic timer_out_signal;
    } rdt_regs_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } rdt_pin_regs_t;

endpackage : rdt_pkg

// >>> rdt_pin_stage.sv
`timescale 1ns/100ps
module rdt_pin_stage
    import rdt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    // ------------------------------------------------------------------
    // Two-flop synchroniser and edge detector
    // ------------------------------------------------------------------
    rdt_pin_regs_t st;
    rdt_pin_regs_t next_st;

    always_comb begin
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // The first stage feeds only the second; all decoding uses later stages.
    assign level_o = st.s2;
    assign rise_o = st.s2 & ~st.s3;
    assign fall_o = ~st.s2 & st.s3;

endmodule : rdt_pin_stage

// >>> rdt_timer.sv
// Contract
// RL1: Internal count clock is machine clock divided by 2, 8 or 32.
// RL2: Trigger bit starts counting while enabled; both bits together start at once.
// RL3: Reload value enters the counter one clock after the trigger.
// RL4: Underflow is the step from zero to all ones.
// RL5: Underflow reloads when reload enabled, else stops holding all ones.
// RL6: Underflow sets the flag; interrupt when flag and enable are both set.
// RL7: Valid input edge loads, clears the prescaler and starts, within 2T to 2.5T; the code loads 3T to 4T after the pin change.
// RL8: The external source holds each input pulse at least two clocks.
// RL9: Gate mode counts only at the chosen level; prescaler runs; triggers accepted.
// RL10: External clock source counts chosen edges of the input pin.
// RL11: Output toggles on reload-mode underflow; one-shot output active while counting.
// RL12: Level select zero gives low toggle start, high pulse; one inverts both.
// RL13: Interrupt request asks for DMA; DMA acceptance clears the flag.
// RL14: Three states: stopped, trigger wait, running, chosen by a wait signal.
// RL15: Software triggers before the gate level arrives in gate mode.
// RL16: Software sets the trigger bit in the same write as the enable.
// RL17: Simultaneous hardware set and software clear leave the flag set.
// RL18: Reload value written during a reload takes effect at the next one.
// RL19: A load coinciding with a decrement wins and the decrement is skipped.
// RL20: Clock select 00, 01, 10 divide by 2, 8, 32; 11 is external.
// RL21: Gate select, edge field and gate level bit decode as documented.
// RL22: Writing zero clears the flag, one does nothing; modify reads return one.
// RL23: Triggers need enable; clearing enable stops; trigger bit reads zero.
`timescale 1ns/100ps
module rdt_timer
    import rdt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [RDT_AW-1:0] addr_i,
    input wire logic [RDT_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic rd_rmw_i,
    output logic [RDT_DW-1:0] rdata_o,
    input wire logic timer_input_pin_i,
    output logic timer_output_pin_o,
    output logic irq_o,
    output logic dma_req_o,
    input wire logic dma_ack_i
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            RDT_EDGE_NONE: hit = 1'b0;
            RDT_EDGE_RISE: hit = rise;
            RDT_EDGE_FALL: hit = fall;
            RDT_EDGE_BOTH: hit = rise | fall;
        endcase
        return hit;
    endfunction : edge_hit

    function automatic logic presc_tick(input logic [1:0] csl, input logic [4:0] presc);
        logic [4:0] mask;
        mask = RDT_MASK_DIV32;
        unique case (csl)
            RDT_CSL_DIV2: mask = RDT_MASK_DIV2;
            RDT_CSL_DIV8: mask = RDT_MASK_DIV8;
            RDT_CSL_DIV32: mask = RDT_MASK_DIV32;
            RDT_CSL_EXT: mask = RDT_MASK_DIV32;
        endcase
        return (presc & mask) == mask;
    endfunction : presc_tick

    // ------------------------------------------------------------------
    // Input pin stage
    // ------------------------------------------------------------------
    logic pin_level;
    logic pin_rise;
    logic pin_fall;

    rdt_pin_stage u_pin (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .pin_i(timer_input_pin_i),
        .level_o(pin_level),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // ------------------------------------------------------------------
    // Events of this cycle
    // ------------------------------------------------------------------
    rdt_regs_t st;
    rdt_regs_t next_st;
    logic csr_wr;
    logic sw_trig;
    logic ext_trig;
    logic running;
    logic gate_ok;
    logic cnt_tick;
    logic uf_evt;
    logic stop_wr;

    assign csr_wr = wr_i && (addr_i == RDT_OFS_CSR);
    assign stop_wr = csr_wr && !wdata_i[RDT_B_COUNT_RUN_ENABLE];
    // Enable and trigger may arrive in one write, so the new enable value counts.
    assign sw_trig = csr_wr && wdata_i[RDT_B_TRG] && wdata_i[RDT_B_COUNT_RUN_ENABLE]; // RL2 RL23
    assign ext_trig = (st.state != RDT_ST_STOP) && (st.csl != RDT_CSL_EXT)
                      && !st.mode[2] && edge_hit(st.mode[1:0], pin_rise, pin_fall); // RL7 RL21
    assign running = (st.state == RDT_ST_RUN);
    assign gate_ok = !st.mode[2] || (st.csl == RDT_CSL_EXT)
                     || (pin_level == st.mode[0]); // RL9 RL21
    assign cnt_tick = running && gate_ok && ((st.csl == RDT_CSL_EXT)
                      ? edge_hit(st.mode[1:0], pin_rise, pin_fall) // RL10
                      : presc_tick(st.csl, st.presc)); // RL1 RL20
    // A pending load beats a decrement in the same cycle.
    assign uf_evt = cnt_tick && (st.count == RDT_CNT_RST) && !st.load_pend; // RL4 RL19

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = '0;
        if (running) begin
            next_st.presc = st.presc + 5'h01; // RL9
        end
        if (cnt_tick && !st.load_pend) begin
            if (uf_evt) begin
                if (st.reload_enable) begin
                    next_st.count = st.reload; // RL5 RL18
                    next_st.tog = ~st.tog; // RL11
                end else begin
                    next_st.count = RDT_CNT_ALL_ONES; // RL5
                    next_st.state = RDT_ST_WAIT; // RL14
                end
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
        // Trigger acted on one cycle late; this register is the wait signal's clear.
        if (st.load_pend) begin
            next_st.count = st.reload; // RL3 RL19
            next_st.presc = '0; // RL7
            next_st.state = RDT_ST_RUN; // RL14
            next_st.tog = 1'b0; // RL12
            next_st.load_pend = 1'b0;
        end
        if (csr_wr) begin
            next_st.csl = wdata_i[RDT_B_CSL_HI:RDT_B_CSL_LO];
            next_st.mode = wdata_i[RDT_B_MOD_HI:RDT_B_MOD_LO];
            next_st.output_level_select = wdata_i[RDT_B_OUTPUT_LEVEL_SELECT];
            next_st.reload_enable = wdata_i[RDT_B_RELOAD_ENABLE];
            next_st.underflow_irq_enable = wdata_i[RDT_B_UNDERFLOW_IRQ_ENABLE];
            if (!wdata_i[RDT_B_UF]) begin
                next_st.uf = 1'b0; // RL22
            end
            if (stop_wr) begin
                next_st.state = RDT_ST_STOP; // RL23 RL14
                next_st.load_pend = 1'b0;
            end else if (st.state == RDT_ST_STOP) begin
                next_st.state = RDT_ST_WAIT; // RL14
            end
        end
        if (wr_i && (addr_i == RDT_OFS_RLD)) begin
            next_st.reload = wdata_i; // RL18
        end
        if (dma_ack_i) begin
            next_st.uf = 1'b0; // RL13
        end
        // Setting comes last so that it wins over any clear.
        if (uf_evt) begin
            next_st.uf = 1'b1; // RL6 RL17
        end
        if (sw_trig || (ext_trig && !stop_wr)) begin
            next_st.load_pend = 1'b1; // RL2 RL7
        end
        if (rd_i) begin
            unique case (addr_i)
                RDT_OFS_CSR: begin
                    next_st.rdata = {4'h0, st.csl, st.mode, 1'b0, st.output_level_select, st.reload_enable,
                                     st.underflow_irq_enable, st.uf | rd_rmw_i,
                                     st.state != RDT_ST_STOP, 1'b0}; // RL22 RL23
                end
                RDT_OFS_CNT: next_st.rdata = st.count;
                default: next_st.rdata = '0;
            endcase
        end
        next_st.irq = next_st.uf && next_st.underflow_irq_enable; // RL6
        next_st.dma_req = next_st.uf && next_st.underflow_irq_enable; // RL13
        next_st.timer_out_signal = (next_st.reload_enable ? next_st.tog : (next_st.state == RDT_ST_RUN))
                       ^ next_st.output_level_select; // RL11 RL12
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign timer_output_pin_o = st.timer_out_signal;
    assign irq_o = st.irq;
    assign dma_req_o = st.dma_req;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    soft_trigger_pend_a: assert property (sw_trig |=> st.load_pend) // RL2
        else $error("software trigger did not arm the load");

    load_one_cycle_a: assert property (st.load_pend && !csr_wr
        |=> running && st.count == $past(st.reload)) // RL3
        else $error("reload value not loaded one cycle after trigger");

    uf_stop_ones_a: assert property (uf_evt && !st.reload_enable && !csr_wr
        |=> st.count == 16'hffff && st.state == RDT_ST_WAIT) // RL5
        else $error("counter did not stop at all ones");

    uf_reload_a: assert property (uf_evt && st.reload_enable && !st.load_pend
        |=> st.count == $past(st.reload)) // RL5
        else $error("counter not reloaded on underflow");

    flag_set_wins_a: assert property (uf_evt |=> st.uf) // RL17
        else $error("underflow flag lost against a clear");

    // The request register tracks flag and enable of the same cycle, so a clear
    // in the previous cycle must not be read as a missing request.
    irq_follows_flag_a: assert property (st.uf && st.underflow_irq_enable |-> irq_o && dma_req_o) // RL6
        else $error("interrupt request missing while flag enabled");

    dma_clears_flag_a: assert property (dma_ack_i && !uf_evt |=> !st.uf) // RL13
        else $error("DMA acknowledge did not clear the flag");

    toggle_on_uf_a: assert property (uf_evt && st.reload_enable && !csr_wr && !st.load_pend
        |=> timer_output_pin_o != $past(timer_output_pin_o)) // RL11
        else $error("toggle output did not invert on underflow");

    trg_reads_zero_a: assert property (rd_i && addr_i == RDT_OFS_CSR |=> !rdata_o[0]) // RL23
        else $error("trigger bit read back as one");

    gate_hold_a: assert property (running && st.mode[2] && st.csl != RDT_CSL_EXT
        && pin_level != st.mode[0] && !st.load_pend && !csr_wr
        |=> st.count == $past(st.count)) // RL9
        else $error("counter moved outside the gate level");

    // ------------------------------------------------------------------
    // Further checks on state, prescaler and pins
    // ------------------------------------------------------------------
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000) // RL23
        else $error("read data not zero outside a read");

    stop_write_a: assert property (stop_wr |=> st.state == RDT_ST_STOP) // RL23
        else $error("clearing the enable did not stop the counter");

    enable_wait_a: assert property (csr_wr && wdata_i[RDT_B_COUNT_RUN_ENABLE] && !wdata_i[RDT_B_TRG]
        && st.state == RDT_ST_STOP |=> st.state == RDT_ST_WAIT) // RL14
        else $error("enable without trigger did not enter the wait state");

    trig_needs_enable_a: assert property (csr_wr && !wdata_i[RDT_B_COUNT_RUN_ENABLE]
        |=> !st.load_pend) // RL23
        else $error("trigger armed without the enable");

    presc_clear_a: assert property (st.load_pend |=> st.presc == 5'h00) // RL7
        else $error("prescaler not cleared at load");

    presc_runs_a: assert property (running && !st.load_pend && st.csl != RDT_CSL_EXT
        |=> st.presc == $past(st.presc) + 5'h01) // RL9
        else $error("prescaler stalled while running");

    idle_hold_a: assert property (!running && !st.load_pend
        |=> st.count == $past(st.count)) // RL14
        else $error("counter moved while not running");

    count_step_a: assert property (cnt_tick && !st.load_pend && st.count != RDT_CNT_RST
        |=> st.count == $past(st.count) - 16'h0001) // RL4
        else $error("counter did not step down by one");

    load_wins_a: assert property (st.load_pend && cnt_tick
        |=> st.count == $past(st.reload)) // RL19
        else $error("decrement not skipped during a load");

    event_step_a: assert property (running && st.csl == RDT_CSL_EXT && pin_rise
        && st.mode[1:0] == RDT_EDGE_RISE && !st.load_pend && st.count != RDT_CNT_RST
        |=> st.count == $past(st.count) - 16'h0001) // RL10
        else $error("external event not counted");

    irq_masked_a: assert property (!st.underflow_irq_enable |-> !irq_o && !dma_req_o) // RL6
        else $error("request raised while the interrupt is disabled");

    oneshot_out_a: assert property (!st.reload_enable
        |-> timer_output_pin_o == (running ^ st.output_level_select)) // RL11
        else $error("one-shot output does not follow the running state");

endmodule : rdt_timer

// >>> rdt_pin_src.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Far-side source for the timer input pin
// ----------------------------------------------------------------------
module rdt_pin_src (
    input wire logic mclk_i,
    output logic pin_o
);
    initial pin_o = 1'b0;

    task automatic level(input logic v);
        @(posedge mclk_i);
        pin_o <= v;
    endtask : level

    // Pulses and gaps never go below two clocks, since the pin is synchronised by the block.
    task automatic pulse(input int n);
        int w;
        for (int i = 0; i < n; i++) begin
            w = 2 + $urandom_range(0, 2);
            @(posedge mclk_i);
            pin_o <= 1'b1;
            repeat (w) @(posedge mclk_i);
            pin_o <= 1'b0;
            repeat (2) @(posedge mclk_i);
        end
    endtask : pulse
endmodule : rdt_pin_src

// >>> testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import rdt_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [RDT_AW-1:0] addr_i = '0;
    logic [RDT_DW-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_rmw_i = 1'b0;
    logic dma_ack_i = 1'b0;
    logic [RDT_DW-1:0] rdata_o;
    logic pin, timer_out_signal, irq, dreq;
    logic [15:0] rv;
    int failures = 0;
    int check_count = 0;
    int cyc, r, n, k;

    always #2.5 mclk_i = ~mclk_i;

    rdt_timer i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rd_rmw_i(rd_rmw_i), .rdata_o(rdata_o),
        .timer_input_pin_i(pin), .timer_output_pin_o(timer_out_signal), .irq_o(irq),
        .dma_req_o(dreq), .dma_ack_i(dma_ack_i));
    rdt_pin_src i_src (.mclk_i(mclk_i), .pin_o(pin));

    // ------------------------------------------------------------------
    // Bus and wait helpers
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [3:0] a, input logic rmw, output logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        rd_rmw_i <= rmw;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        rd_rmw_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    task automatic wait_lvl(input logic lvl, output int c);
        c = 0;
        while (timer_out_signal !== lvl && c < 3000) begin
            @(posedge mclk_i);
            #1 c++;
        end
    endtask : wait_lvl

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #(30000 * 5);
        failures++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h62f6));
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd(RDT_OFS_CSR, 1'b0, rv); `CHK(rv, 16'h0000)
        rd(RDT_OFS_CNT, 1'b0, rv); `CHK(rv, RDT_CNT_RST)
        rd(RDT_OFS_RLD, 1'b0, rv); `CHK(rv, 16'h0000)
        rd(4'hc, 1'b0, rv); `CHK(rv, 16'h0000)
        $display("test reset done");
        // The third interval is used because a reload may first snap the pin to its start level.
        for (int m = 0; m < 3; m++) begin
            n = 2 << (2 * m);
            r = $urandom_range(1, 6);
            wr(RDT_OFS_RLD, 16'(r));
            wr(RDT_OFS_CSR, {4'h0, 2'(m), 10'h013});
            repeat (3) wait_lvl(~timer_out_signal, cyc);
            `CHK(cyc, (r + 1) * n)
        end
        wr(RDT_OFS_CSR, 16'h0033);
        repeat (3) @(posedge mclk_i);
        #1 `CHK(timer_out_signal, 1'b1)
        $display("test reload done");
        wr(RDT_OFS_CSR, 16'h0000);
        repeat (2) @(posedge mclk_i);
        #1 `CHK(timer_out_signal, 1'b0)
        wr(RDT_OFS_RLD, 16'h0005);
        wr(RDT_OFS_CSR, 16'h000b);
        wait_lvl(1'b1, cyc);
        wait_lvl(1'b0, cyc);
        `CHK(cyc, 12)
        rd(RDT_OFS_CNT, 1'b0, rv); `CHK(rv, RDT_CNT_ALL_ONES)
        repeat (2) @(posedge mclk_i);
        #1 `CHK(irq & dreq, 1'b1)
        rd(RDT_OFS_CSR, 1'b0, rv); `CHK(rv, 16'h000e)
        wr(RDT_OFS_CSR, 16'h000e);
        rd(RDT_OFS_CSR, 1'b0, rv); `CHK(rv, 16'h000e)
        wr(RDT_OFS_CSR, 16'h000a);
        rd(RDT_OFS_CSR, 1'b0, rv); `CHK(rv, 16'h000a)
        rd(RDT_OFS_CSR, 1'b1, rv); `CHK(rv, 16'h000e)
        #1 `CHK(irq, 1'b0)
        $display("test one-shot done");
        wr(RDT_OFS_CSR, 16'h008a);
        i_src.pulse(1);
        wait_lvl(1'b1, cyc);
        `CHK(timer_out_signal, 1'b1)
        wait_lvl(1'b0, cyc);
        repeat (2) @(posedge mclk_i);
        #1 `CHK(irq, 1'b1)
        @(posedge mclk_i);
        dma_ack_i <= 1'b1;
        @(posedge mclk_i);
        dma_ack_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 `CHK(irq | dreq, 1'b0)
        $display("test trigger done");
        wr(RDT_OFS_RLD, 16'h0100);
        wr(RDT_OFS_CSR, 16'h0c93);
        repeat (4) @(posedge mclk_i);
        rd(RDT_OFS_CNT, 1'b0, rv); `CHK(rv, 16'h0100)
        k = $urandom_range(3, 9);
        i_src.pulse(k);
        repeat (5) @(posedge mclk_i);
        rd(RDT_OFS_CNT, 1'b0, rv); `CHK(rv, 16'(256 - k))
        $display("test event done");
        wr(RDT_OFS_CSR, 16'h0283);
        repeat (20) @(posedge mclk_i);
        rd(RDT_OFS_CNT, 1'b0, rv); `CHK(rv, 16'h0100)
        i_src.level(1'b1);
        repeat (20) @(posedge mclk_i);
        i_src.level(1'b0);
        repeat (5) @(posedge mclk_i);
        rd(RDT_OFS_CNT, 1'b0, rv); `CHK(rv < 16'h0100, 1'b1)
        $display("test gate done");
        conclude();
    end
endmodule : testbench
